/* pinmux_cfg.svh */
`ifndef PINMUX_CFG_SVH
`define PINMUX_CFG_SVH

// ----------------------------------------------------------------
// Port widths
// ----------------------------------------------------------------
`define PORT1_WIDTH 3
`define PORT2_WIDTH 6
`define PORT3_WIDTH 4
`define SYNC_WIDTH 16

// ----------------------------------------------------------------
// Register word indices (byte address is index times four)
// ----------------------------------------------------------------
`define OFS_PORT1_DIRECTION 6'h00
`define OFS_PORT1_PULLUP 6'h01
`define OFS_PORT1_FUNCTION 6'h02
`define OFS_PORT1_CONTROL 6'h03
`define OFS_PORT1_LATCH 6'h04
`define OFS_PORT1_PINS 6'h05
`define OFS_PORT2_DIRECTION 6'h06
`define OFS_PORT2_FUNCTION 6'h07
`define OFS_PORT2_ANALOG 6'h08
`define OFS_PORT2_LATCH 6'h09
`define OFS_PORT2_PINS 6'h0a
`define OFS_PORT3_DIRECTION 6'h0b
`define OFS_PORT3_PULLUP 6'h0c
`define OFS_PORT3_CONTROL 6'h0d
`define OFS_PORT3_SELECT 6'h0e
`define OFS_PORT3_LATCH 6'h0f
`define OFS_PORT3_PINS 6'h10
`define OFS_INPUT_SWITCH 6'h11
`define OFS_DEBUG_CONTROL 6'h12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PORT1_DIRECTION 3'h7
`define RST_PORT2_DIRECTION 6'h3f
`define RST_PORT2_ANALOG 6'h3f
`define RST_PORT3_DIRECTION 4'hf

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define P1_BIT_SERIAL_CLOCK 0
`define P1_BIT_SERIAL_IN 1
`define P1_BIT_SERIAL_OUT 2
`define P1_FUNC_UART_TX 0
`define ISC_UART_B_SHARED 0
`define DBG_PINS_ENABLE 0
`define P3_SEL_INPUT 2'h3
`define P3_BIT_INT3 0
`define P3_BIT_TOH0 1
`define P3_BIT_COUNT_CAPTURE 2
`define P3_BIT_CAPTURE 3

`endif

/* pinmux_pkg.sv */
`include "pinmux_cfg.svh"

package pinmux_pkg;

  // Levels arriving on the device pins
  typedef struct packed {
    logic [`PORT1_WIDTH-1:0] p1;
    logic [`PORT2_WIDTH-1:0] p2;
    logic [`PORT3_WIDTH-1:0] p3;
    logic main_osc_in;
    logic main_osc_out;
    logic uart_b_rx_home;
  } pads_in_type;

  // Drive and enable per pin, with pull-up on ports 1 and 3 and analog mode on port 2
  typedef struct packed {
    logic [`PORT1_WIDTH-1:0] p1_out;
    logic [`PORT1_WIDTH-1:0] p1_oe;
    logic [`PORT1_WIDTH-1:0] p1_pullup;
    logic [`PORT2_WIDTH-1:0] p2_out;
    logic [`PORT2_WIDTH-1:0] p2_oe;
    logic [`PORT2_WIDTH-1:0] p2_analog;
    logic [`PORT3_WIDTH-1:0] p3_out;
    logic [`PORT3_WIDTH-1:0] p3_oe;
    logic [`PORT3_WIDTH-1:0] p3_pullup;
  } pads_out_type;

  // Signals the on-chip peripherals offer to the pins
  typedef struct packed {
    logic sync_serial_clock_out;
    logic sync_serial_master;
    logic sync_serial_data_out;
    logic uart_a_transmit;
    logic uart_b_transmit;
    logic [`PORT2_WIDTH-1:0] lcd_segment_outputs;
    logic timer16_out;
    logic timer8_h0_out;
    logic timer8_h1_out;
    logic buzzer_out;
    logic rtc_divided_out;
    logic rtc_raw_out;
    logic rtc_1hz_out;
    logic manchester_out;
    logic capture_a_from_count_pin;
  } periph_drive_type;

  // Pin levels handed to the on-chip peripherals
  typedef struct packed {
    logic [2:0] key_interrupt_inputs;
    logic sync_serial_data_in;
    logic sync_serial_clock;
    logic uart_a_receive;
    logic uart_b_receive;
    logic [`PORT2_WIDTH-1:0] analog_inputs;
    logic [2:0] ext_interrupts;
    logic timer16_count_capture_in;
    logic timer16_capture_a;
    logic timer16_capture_b;
    logic timer8_count_clock_in;
    logic debug_mode_pin_a;
    logic debug_mode_pin_b;
  } periph_sense_type;

  // Whole state of the mux block
  typedef struct packed {
    logic [`PORT1_WIDTH-1:0] port1_direction;
    logic [`PORT1_WIDTH-1:0] port1_pullup_enable;
    logic port1_function_select;
    logic [`PORT1_WIDTH-1:0] port1_control;
    logic [`PORT1_WIDTH-1:0] port1_latch;
    logic [`PORT2_WIDTH-1:0] port2_direction;
    logic [`PORT2_WIDTH-1:0] port2_function_select;
    logic [`PORT2_WIDTH-1:0] port2_analog_mode;
    logic [`PORT2_WIDTH-1:0] port2_latch;
    logic [`PORT3_WIDTH-1:0] port3_direction;
    logic [`PORT3_WIDTH-1:0] port3_pullup_enable;
    logic [`PORT3_WIDTH-1:0] port3_control;
    logic [2*`PORT3_WIDTH-1:0] port3_select;
    logic [`PORT3_WIDTH-1:0] port3_latch;
    logic input_switch_control;
    logic debug_pins_enable;
    logic waitrequest;
    logic [31:0] readdata;
    pads_out_type pads;
    periph_sense_type sense;
  } mux_state_type;

endpackage : pinmux_pkg

/* pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Asynchronous levels in, settled levels out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } sync_state_type;

  sync_state_type state_reg;
  sync_state_type state_next;

  // Three stages; a bit changes once stages two and three agree
  always_comb
  begin
    state_next = state_reg;
    state_next.stage1 = din;
    state_next.stage2 = state_reg.stage1;
    state_next.stage3 = state_reg.stage2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (state_reg.stage2[i] == state_reg.stage3[i])
      begin
        state_next.level[i] = state_reg.stage3[i];
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.level;

endmodule : pin_sync

`default_nettype wire

/* port_pin_function_mux.sv */
// Contract
// - Per-bit direction for the three port-1 pins
// - Port-1 pull-up follows pull-up enable bits on input pins
// - Port-1 control mode: key inputs, serial signals
// - Function select picks top port-1 pin function
// - Port-2 pins: general I/O or LCD segment
// - Per-bit direction for the port-2 pins
// - Port-2 pins start in analog input mode
// - Port-2 analog mode bits feed converter analog inputs
// - Input switch moves second UART onto shared pins
// - Port-1 and port-3 pins come up as general inputs
// - Serial clock bidirectional by role; data pins one-way
// - Second trigger feeds capture A; first feeds both
// - Port-3 pins: I/O or timer, buzzer, clock functions
// - Oscillator pins become debug mode inputs
// - Port-3 direction and pull-up registers per bit
`timescale 1ns/1ns
`default_nettype none
`include "pinmux_cfg.svh"

module port_pin_function_mux #(
  parameter bit HAS_ADC = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Device pins
  input wire pinmux_pkg::pads_in_type pads_in,
  output pinmux_pkg::pads_out_type pads_out,
  // On-chip peripherals
  input wire pinmux_pkg::periph_drive_type periph_drive,
  output pinmux_pkg::periph_sense_type periph_sense
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Pin read: settled level on inputs, latch on outputs
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] level);
    port_read = (dir & level) | (~dir & latch);
  endfunction : port_read

  // Port-3 output source for one pin and select code
  function automatic logic p3_source(input int pin, input logic [1:0] sel,
                                     input pinmux_pkg::periph_drive_type drv);
    p3_source = 1'b0;
    unique case (pin)
      0: p3_source = drv.timer8_h1_out;
      1: p3_source = (sel == 2'h0) ? drv.timer8_h0_out : drv.manchester_out;
      2:
      begin
        unique case (sel)
          2'h0: p3_source = drv.buzzer_out;
          2'h1: p3_source = drv.rtc_divided_out;
          default: p3_source = drv.rtc_raw_out;
        endcase
      end
      default: p3_source = (sel == 2'h0) ? drv.timer16_out : drv.rtc_1hz_out;
    endcase
  endfunction : p3_source

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [`SYNC_WIDTH-1:0] sync_level;
  logic [`PORT1_WIDTH-1:0] p1_level;
  logic [`PORT2_WIDTH-1:0] p2_level;
  logic [`PORT3_WIDTH-1:0] p3_level;
  logic osc_in_level;
  logic osc_out_level;
  logic uart_b_home_level;

  pin_sync #(
    .WIDTH(`SYNC_WIDTH)
  ) pin_sync_inst (
    .ref_clk(ref_clk),
    .srst(srst),
    .din({pads_in.p1, pads_in.p2, pads_in.p3, pads_in.main_osc_in,
          pads_in.main_osc_out, pads_in.uart_b_rx_home}),
    .dout(sync_level)
  );

  // Split the settled levels back per port
  assign {p1_level, p2_level, p3_level, osc_in_level, osc_out_level,
          uart_b_home_level} = sync_level;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pinmux_pkg::mux_state_type state_reg;
  pinmux_pkg::mux_state_type state_next;
  logic [5:0] word_index;
  logic bus_take;
  logic bus_commit;

  // Bus decode
  assign word_index = avs_address[7:2];
  assign bus_take = (avs_read || avs_write) && state_reg.waitrequest;
  assign bus_commit = avs_write && !state_reg.waitrequest && avs_byteenable[0];

  // Register file, pin routing and peripheral routing
  always_comb
  begin
    logic [1:0] sel;
    logic in_fn;
    sel = 2'h0;
    in_fn = 1'b0;
    state_next = state_reg;

    // Bus handshake: one wait cycle, then one ready cycle
    state_next.waitrequest = !bus_take;
    if (bus_take)
    begin
      if (avs_read)
      begin
        state_next.readdata = 32'h0000_0000;
        unique case (word_index)
          `OFS_PORT1_DIRECTION: state_next.readdata[2:0] = state_reg.port1_direction;
          `OFS_PORT1_PULLUP: state_next.readdata[2:0] = state_reg.port1_pullup_enable;
          `OFS_PORT1_FUNCTION: state_next.readdata[0] = state_reg.port1_function_select;
          `OFS_PORT1_CONTROL: state_next.readdata[2:0] = state_reg.port1_control;
          `OFS_PORT1_LATCH: state_next.readdata[2:0] = state_reg.port1_latch;
          `OFS_PORT1_PINS: state_next.readdata[7:0] = port_read({5'h00,
            state_reg.port1_direction}, {5'h00, state_reg.port1_latch},
            {5'h00, p1_level}); // Padded bits read back as zero
          `OFS_PORT2_DIRECTION: state_next.readdata[5:0] = state_reg.port2_direction;
          `OFS_PORT2_FUNCTION: state_next.readdata[5:0] = state_reg.port2_function_select;
          `OFS_PORT2_ANALOG: state_next.readdata[5:0] = state_reg.port2_analog_mode;
          `OFS_PORT2_LATCH: state_next.readdata[5:0] = state_reg.port2_latch;
          `OFS_PORT2_PINS: state_next.readdata[7:0] = port_read({2'h0,
            state_reg.port2_direction}, {2'h0, state_reg.port2_latch},
            {2'h0, p2_level}); // Padded bits read back as zero
          `OFS_PORT3_DIRECTION: state_next.readdata[3:0] = state_reg.port3_direction;
          `OFS_PORT3_PULLUP: state_next.readdata[3:0] = state_reg.port3_pullup_enable;
          `OFS_PORT3_CONTROL: state_next.readdata[3:0] = state_reg.port3_control;
          `OFS_PORT3_SELECT: state_next.readdata[7:0] = state_reg.port3_select;
          `OFS_PORT3_LATCH: state_next.readdata[3:0] = state_reg.port3_latch;
          `OFS_PORT3_PINS: state_next.readdata[7:0] = port_read({4'h0,
            state_reg.port3_direction}, {4'h0, state_reg.port3_latch},
            {4'h0, p3_level}); // Padded bits read back as zero
          `OFS_INPUT_SWITCH: state_next.readdata[0] = state_reg.input_switch_control;
          `OFS_DEBUG_CONTROL: state_next.readdata[0] = state_reg.debug_pins_enable;
          default: state_next.readdata = 32'h0000_0000; // Unmapped reads zero
        endcase
      end
    end

    // Register writes land on the ready cycle; unmapped writes dropped
    if (bus_commit)
    begin
      unique case (word_index)
        `OFS_PORT1_DIRECTION: state_next.port1_direction = avs_writedata[2:0];
        `OFS_PORT1_PULLUP: state_next.port1_pullup_enable = avs_writedata[2:0];
        `OFS_PORT1_FUNCTION: state_next.port1_function_select = avs_writedata[0];
        `OFS_PORT1_CONTROL: state_next.port1_control = avs_writedata[2:0];
        `OFS_PORT1_LATCH: state_next.port1_latch = avs_writedata[2:0];
        `OFS_PORT2_DIRECTION: state_next.port2_direction = avs_writedata[5:0];
        `OFS_PORT2_FUNCTION: state_next.port2_function_select = avs_writedata[5:0];
        `OFS_PORT2_ANALOG: state_next.port2_analog_mode = avs_writedata[5:0];
        `OFS_PORT2_LATCH: state_next.port2_latch = avs_writedata[5:0];
        `OFS_PORT3_DIRECTION: state_next.port3_direction = avs_writedata[3:0];
        `OFS_PORT3_PULLUP: state_next.port3_pullup_enable = avs_writedata[3:0];
        `OFS_PORT3_CONTROL: state_next.port3_control = avs_writedata[3:0];
        `OFS_PORT3_SELECT: state_next.port3_select = avs_writedata[7:0];
        `OFS_PORT3_LATCH: state_next.port3_latch = avs_writedata[3:0];
        `OFS_INPUT_SWITCH: state_next.input_switch_control = avs_writedata[0];
        `OFS_DEBUG_CONTROL: state_next.debug_pins_enable = avs_writedata[0];
        default: state_next.waitrequest = state_next.waitrequest; // Ignored
      endcase
    end

    // Port 1 pins
    for (int i = 0; i < `PORT1_WIDTH; i++)
    begin
      state_next.pads.p1_out[i] = state_reg.port1_latch[i];
      state_next.pads.p1_oe[i] = !state_reg.port1_direction[i];
      state_next.pads.p1_pullup[i] = state_reg.port1_pullup_enable[i] &&
                                     state_reg.port1_direction[i];
    end
    if (state_reg.port1_control[`P1_BIT_SERIAL_CLOCK])
    begin
      // Clock driven as master, received as slave
      state_next.pads.p1_out[`P1_BIT_SERIAL_CLOCK] = periph_drive.sync_serial_clock_out;
      state_next.pads.p1_oe[`P1_BIT_SERIAL_CLOCK] = periph_drive.sync_serial_master;
    end
    if (state_reg.port1_control[`P1_BIT_SERIAL_IN])
    begin
      state_next.pads.p1_oe[`P1_BIT_SERIAL_IN] = 1'b0;
    end
    if (state_reg.port1_control[`P1_BIT_SERIAL_OUT])
    begin
      state_next.pads.p1_oe[`P1_BIT_SERIAL_OUT] = 1'b1;
      if (state_reg.port1_function_select == 1'(`P1_FUNC_UART_TX))
      begin
        state_next.pads.p1_out[`P1_BIT_SERIAL_OUT] =
          state_reg.input_switch_control ? periph_drive.uart_b_transmit
                                         : periph_drive.uart_a_transmit;
      end
      else
      begin
        state_next.pads.p1_out[`P1_BIT_SERIAL_OUT] = periph_drive.sync_serial_data_out;
      end
    end

    // Port 2 pins: analog, then segment, then general port
    for (int i = 0; i < `PORT2_WIDTH; i++)
    begin
      state_next.pads.p2_analog[i] = state_reg.port2_analog_mode[i];
      if (state_reg.port2_analog_mode[i])
      begin
        state_next.pads.p2_out[i] = 1'b0;
        state_next.pads.p2_oe[i] = 1'b0;
      end
      else if (state_reg.port2_function_select[i])
      begin
        state_next.pads.p2_out[i] = periph_drive.lcd_segment_outputs[i];
        state_next.pads.p2_oe[i] = 1'b1;
      end
      else
      begin
        state_next.pads.p2_out[i] = state_reg.port2_latch[i];
        state_next.pads.p2_oe[i] = !state_reg.port2_direction[i];
      end
    end

    // Port 3 pins
    for (int i = 0; i < `PORT3_WIDTH; i++)
    begin
      sel = state_reg.port3_select[2*i +: 2];
      state_next.pads.p3_pullup[i] = state_reg.port3_pullup_enable[i] &&
                                     state_reg.port3_direction[i];
      if (state_reg.port3_control[i] && sel != `P3_SEL_INPUT)
      begin
        state_next.pads.p3_out[i] = p3_source(i, sel, periph_drive);
        state_next.pads.p3_oe[i] = 1'b1;
      end
      else if (state_reg.port3_control[i])
      begin
        state_next.pads.p3_out[i] = 1'b0;
        state_next.pads.p3_oe[i] = 1'b0;
      end
      else
      begin
        state_next.pads.p3_out[i] = state_reg.port3_latch[i];
        state_next.pads.p3_oe[i] = !state_reg.port3_direction[i];
      end
    end

    // Port 1 levels to key interrupts and serial receivers
    for (int i = 0; i < `PORT1_WIDTH; i++)
    begin
      state_next.sense.key_interrupt_inputs[i] = state_reg.port1_control[i] &&
                                                 p1_level[i];
    end
    state_next.sense.sync_serial_clock = state_reg.port1_control[`P1_BIT_SERIAL_CLOCK] &&
                                         p1_level[`P1_BIT_SERIAL_CLOCK];
    in_fn = state_reg.port1_control[`P1_BIT_SERIAL_IN] && p1_level[`P1_BIT_SERIAL_IN];
    state_next.sense.sync_serial_data_in = in_fn;
    if (state_reg.input_switch_control)
    begin
      state_next.sense.uart_a_receive = 1'b1; // Idle while rerouted
      state_next.sense.uart_b_receive = in_fn;
    end
    else
    begin
      state_next.sense.uart_a_receive = in_fn;
      state_next.sense.uart_b_receive = uart_b_home_level;
    end

    // Port 2 analog mode bits to the converter
    state_next.sense.analog_inputs = HAS_ADC ? state_reg.port2_analog_mode
                                             : {`PORT2_WIDTH{1'b0}};

    // Port 3 levels to interrupts and timers
    for (int i = 0; i < `PORT3_WIDTH; i++)
    begin
      sel = state_reg.port3_select[2*i +: 2];
      if (i == `P3_BIT_INT3)
      begin
        state_next.sense.ext_interrupts[2] = state_reg.port3_control[i] &&
          sel == `P3_SEL_INPUT && p3_level[i];
      end
    end
    in_fn = state_reg.port3_control[`P3_BIT_COUNT_CAPTURE] &&
            state_reg.port3_select[2*`P3_BIT_COUNT_CAPTURE +: 2] == `P3_SEL_INPUT &&
            p3_level[`P3_BIT_COUNT_CAPTURE];
    state_next.sense.ext_interrupts[1] = in_fn;
    state_next.sense.timer16_count_capture_in = in_fn;
    state_next.sense.timer16_capture_b = in_fn;
    state_next.sense.ext_interrupts[0] = state_reg.port3_control[`P3_BIT_CAPTURE] &&
      state_reg.port3_select[2*`P3_BIT_CAPTURE +: 2] == `P3_SEL_INPUT &&
      p3_level[`P3_BIT_CAPTURE];
    state_next.sense.timer8_count_clock_in = state_next.sense.ext_interrupts[0];
    state_next.sense.timer16_capture_a = periph_drive.capture_a_from_count_pin ? in_fn
      : state_next.sense.ext_interrupts[0];

    // Oscillator pins as debug mode inputs
    state_next.sense.debug_mode_pin_a = state_reg.debug_pins_enable && osc_in_level;
    state_next.sense.debug_mode_pin_b = state_reg.debug_pins_enable && osc_out_level;
  end

  // State register; all multiplexed pins start as inputs
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg <= '0;
      state_reg.port1_direction <= `RST_PORT1_DIRECTION;
      state_reg.port2_direction <= `RST_PORT2_DIRECTION;
      state_reg.port2_analog_mode <= `RST_PORT2_ANALOG;
      state_reg.port3_direction <= `RST_PORT3_DIRECTION;
      state_reg.pads.p2_analog <= `RST_PORT2_ANALOG;
      state_reg.waitrequest <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = state_reg.readdata;
  assign avs_waitrequest = state_reg.waitrequest;
  assign pads_out = state_reg.pads;
  assign periph_sense = state_reg.sense;

endmodule : port_pin_function_mux

`default_nettype wire

/* board_model.sv */
`timescale 1ns/1ns
`default_nettype none

module board_model (
  // Device pin drive
  input wire pinmux_pkg::pads_out_type pads_out,
  // Weak board levels
  input wire pinmux_pkg::pads_in_type ext,
  // Resolved pin levels
  output pinmux_pkg::pads_in_type pads_in
);
  // Driven pins follow the device, otherwise board level or pull-up
  always_comb
  begin
    pads_in = ext;
    pads_in.p1 = (pads_out.p1_oe & pads_out.p1_out) |
      (~pads_out.p1_oe & (ext.p1 | pads_out.p1_pullup));
    pads_in.p2 = (pads_out.p2_oe & pads_out.p2_out) | (~pads_out.p2_oe & ext.p2);
    pads_in.p3 = (pads_out.p3_oe & pads_out.p3_out) |
      (~pads_out.p3_oe & (ext.p3 | pads_out.p3_pullup));
  end
endmodule : board_model

`default_nettype wire

/* pinmux_checker.sv */
`timescale 1ns/1ns
`default_nettype none

module pinmux_checker (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and peripherals
  input wire pinmux_pkg::pads_out_type pads_out,
  input wire pinmux_pkg::periph_drive_type periph_drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Bus answer timing and data
  wait_pulse_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  wait_single_a:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer long");
  read_hold_a:
    assert property (!avs_read |=> $stable(avs_readdata)) else $error("readdata moved");
  unmapped_zero_a:
    assert property (avs_read && avs_waitrequest && avs_address[7:2] > 6'h12
      |=> avs_readdata == 32'h0) else $error("unmapped nonzero");
  // Pin state after reset and analog mode
  analog_reset_a:
    assert property ($fell(srst) |-> pads_out.p2_analog == 6'h3f) else $error("not analog");
  inputs_reset_a:
    assert property ($fell(srst) |-> (pads_out.p1_oe | pads_out.p3_oe) == 4'h0
      && pads_out.p2_oe == 6'h0) else $error("pin driven");
  analog_nodrive_a:
    assert property ((pads_out.p2_analog & pads_out.p2_oe) == 6'h0) else $error("analog driven");
  out_steady_a:
    assert property (!avs_write && !$past(avs_write) && $stable(periph_drive)
      |=> $stable(pads_out)) else $error("pins moved");

  cover property (avs_read && !avs_waitrequest);
  cover property (avs_write && !avs_waitrequest);
  cover property (pads_out.p2_oe == 6'h3f);
endmodule : pinmux_checker

bind port_pin_function_mux pinmux_checker pinmux_checker_inst (.ref_clk(ref_clk),
  .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pads_out(pads_out),
  .periph_drive(periph_drive));

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic ref_clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, be;
  pinmux_pkg::pads_in_type pads_in, ext;
  pinmux_pkg::pads_out_type pads_out;
  pinmux_pkg::periph_drive_type drv;
  pinmux_pkg::periph_sense_type sense;
  int mismatches, compares;

  port_pin_function_mux port_pin_function_mux_inst (.ref_clk(ref_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pads_in(pads_in),
    .pads_out(pads_out), .periph_drive(drv), .periph_sense(sense));
  board_model board_model_inst (.pads_out(pads_out), .ext(ext), .pads_in(pads_in));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One bus access, held until waitrequest low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= {a, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge ref_clk);
    while (avs_waitrequest)
    begin
      @(posedge ref_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : acc

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  // Main sequence
  initial
  begin
    srst = 1'b1;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    be = 4'hf;
    avs_byteenable = 4'hf;
    ext = '0;
    ext.uart_b_rx_home = 1'b1;
    drv = '0;
    drv.lcd_segment_outputs = 6'h15;
    drv.sync_serial_data_out = 1'b1;
    drv.timer8_h1_out = 1'b1;
    drv.buzzer_out = 1'b1;
    mismatches = 0;
    compares = 0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk(32'(pads_out.p2_analog), 32'h3f);
    rd(6'h00, 32'h7);
    rd(6'h06, 32'h3f);
    rd(6'h08, 32'h3f);
    rd(6'h0b, 32'hf);
    wr(6'h04, 32'h5);
    wr(6'h00, 32'h0);
    @(posedge ref_clk);
    chk(32'({pads_out.p1_oe, pads_out.p1_out}), 32'h3d);
    rd(6'h05, 32'h5);
    // Refused writes
    be = 4'h0;
    wr(6'h04, 32'h2);
    be = 4'hf;
    wr(6'h20, 32'hff);
    rd(6'h20, 32'h0);
    rd(6'h04, 32'h5);
    // Pull-ups on inputs
    wr(6'h00, 32'h7);
    wr(6'h01, 32'h6);
    repeat (8) @(posedge ref_clk);
    chk(32'(pads_out.p1_pullup), 32'h6);
    rd(6'h05, 32'h6);
    wr(6'h01, 32'h0);
    // Control mode on port 1
    wr(6'h03, 32'h7);
    @(posedge ref_clk);
    chk(32'(pads_out.p1_out[2]), 32'h0);
    wr(6'h02, 32'h1);
    drv.sync_serial_master <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(32'(pads_out.p1_out[2]), 32'h1);
    chk(32'(pads_out.p1_oe[0]), 32'h1);
    repeat (6) @(posedge ref_clk);
    chk(32'({sense.key_interrupt_inputs, sense.uart_a_receive, sense.uart_b_receive}),
      32'h11);
    wr(6'h11, 32'h1);
    repeat (8) @(posedge ref_clk);
    chk(32'({sense.uart_a_receive, sense.uart_b_receive}), 32'h2);
    // Port 2 modes
    wr(6'h08, 32'h0);
    wr(6'h06, 32'h0);
    wr(6'h09, 32'h2a);
    @(posedge ref_clk);
    chk(32'({pads_out.p2_oe, pads_out.p2_out}), 32'hfea);
    wr(6'h07, 32'h3f);
    @(posedge ref_clk);
    chk(32'(pads_out.p2_out), 32'h15);
    wr(6'h08, 32'h3f);
    repeat (2) @(posedge ref_clk);
    chk(32'({pads_out.p2_oe, sense.analog_inputs}), 32'h3f);
    // Port 3 output functions
    wr(6'h0b, 32'h0);
    wr(6'h0d, 32'hf);
    @(posedge ref_clk);
    chk(32'(pads_out.p3_out), 32'h5);
    wr(6'h0e, 32'h55);
    @(posedge ref_clk);
    chk(32'(pads_out.p3_out), 32'h1);
    // Port 3 pins as trigger inputs, then debug pins
    wr(6'h0e, 32'hff);
    ext.p3 <= 4'h4;
    repeat (8) @(posedge ref_clk);
    chk(32'({sense.timer16_count_capture_in, sense.timer16_capture_a, sense.timer16_capture_b,
      sense.timer8_count_clock_in, sense.ext_interrupts}), 32'h52);
    drv.capture_a_from_count_pin <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(32'(sense.timer16_capture_a), 32'h1);
    ext.main_osc_in <= 1'b1;
    wr(6'h12, 32'h1);
    repeat (8) @(posedge ref_clk);
    chk(32'({sense.debug_mode_pin_a, sense.debug_mode_pin_b}), 32'h2);
    close_out();
  end

  // Watchdog
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
endmodule : tb

`default_nettype wire
